// ==== dpram_cfg.svh ====
/*
 * Register offsets, field positions, reset values and array geometry
 * for the configurable dual-port memory block.
 * Assumes: included by bare name from the package and the design files.
 */
`ifndef DPRAM_CFG_SVH
`define DPRAM_CFG_SVH

// register byte offsets on the apb bus
`define REG_CFG 8'h00
`define REG_STAT 8'h04
`define REG_INIT_ADDR 8'h08
`define REG_INIT_LO 8'h0c
`define REG_INIT_HI 8'h10
`define REG_SHIFT 8'h14

// configuration register fields
`define CFG_MODE 0
`define CFG_W 3
`define CFG_PAR 9
`define CFG_BYP 10
`define CFG_OSEL 12
`define CFG_ISEL 14
`define CFG_RUN 16
`define CFG_BITS 17
`define CFG_RST 17'h00000

// status and shift register fields
`define STAT_ERR 0
`define STAT_EMPTY 1
`define STAT_FULL 2
`define STAT_CNT 16
`define SHIFT_LEN 0
`define SHIFT_TAPS 16

// array geometry
`define RAM_ROWS 128
`define RAM_ROW_W 36
`define RAM_BITS 4608
`define TAP_WMAX 36
`define ADDR_W 12

`endif

// ==== dpram_pkg.sv ====
/*
 * Types shared by the memory block: operating modes and the packed
 * state of the top module.
 * Assumes: dpram_cfg.svh is on the include path.
 */
`include "dpram_cfg.svh"

package dpram_pkg;

    // operating modes; codes 6 and 7 are illegal
    typedef enum logic [2:0] {
        MODE_TDP = 3'h0,
        MODE_SDP = 3'h1,
        MODE_SP = 3'h2,
        MODE_FIFO = 3'h3,
        MODE_ROM = 3'h4,
        MODE_SHIFT = 3'h5
    } mode_t;

    // whole state of the top module
    typedef struct packed {
        logic [`CFG_BITS-1:0] cfg;
        logic [6:0] init_addr;
        logic [3:0] init_hi;
        logic [11:0] tap_len;
        logic [2:0] tap_cnt;
        logic [31:0] prdata;
        logic pslverr;
        logic [1:0][`ADDR_W-1:0] addr_q;
        logic [1:0][`RAM_ROW_W-1:0] out_q;
        logic [`ADDR_W-1:0] wptr;
        logic [`ADDR_W-1:0] rptr;
        logic [12:0] count;
        logic [6:0] sptr;
    } core_t;

endpackage

// ==== ram_array.sv ====
/*
 * Storage array of the memory block: rows of 36 bits, two masked
 * write ports, two combinational read ports.
 * Assumes: write port b wins bit by bit over port a on the same row.
 */
`timescale 1ns/1ns
`include "dpram_cfg.svh"

module ram_array #(
    parameter int ROWS = `RAM_ROWS,
    parameter int ROW_W = `RAM_ROW_W
) (
    // clock
    input wire logic pclk,
    // write port a
    input wire logic we0,
    input wire logic [$clog2(ROWS)-1:0] wrow0,
    input wire logic [ROW_W-1:0] wd0,
    input wire logic [ROW_W-1:0] wm0,
    // write port b
    input wire logic we1,
    input wire logic [$clog2(ROWS)-1:0] wrow1,
    input wire logic [ROW_W-1:0] wd1,
    input wire logic [ROW_W-1:0] wm1,
    // read ports
    input wire logic [$clog2(ROWS)-1:0] rrow0,
    input wire logic [$clog2(ROWS)-1:0] rrow1,
    output logic [ROW_W-1:0] rd0,
    output logic [ROW_W-1:0] rd1
);

    logic [ROW_W-1:0] mem [ROWS];
    logic [ROW_W-1:0] merged0;
    logic [ROW_W-1:0] base1;

    // unmasked bits keep their old value
    assign merged0 = (mem[wrow0] & ~wm0) | (wd0 & wm0);
    assign base1 = (we0 && wrow0 == wrow1) ? merged0 : mem[wrow1];

    // contents carry no reset; software loads them before use
    always_ff @(posedge pclk) begin
        if (we0) begin
            mem[wrow0] <= merged0;
        end
        if (we1) begin
            mem[wrow1] <= (base1 & ~wm1) | (wd1 & wm1);
        end
    end

    assign rd0 = mem[rrow0];
    assign rd1 = mem[rrow1];

endmodule

// ==== lane_map.sv ====
/*
 * Maps one port's logical word onto a 36-bit row and back, for every
 * shape, with byte-mask gating of the write bits.
 * Assumes: wcode is 0..5; with parity set it is 3..5 (9, 18, 36 bits).
 */
`timescale 1ns/1ns

module lane_map (
    // port shape
    input wire logic [2:0] wcode,
    input wire logic parity,
    // write side
    input wire logic [4:0] wsub,
    input wire logic [35:0] wdata,
    input wire logic [3:0] bmask,
    output logic [35:0] phys_d,
    output logic [35:0] phys_m,
    // read side
    input wire logic [4:0] rsub,
    input wire logic [35:0] row,
    output logic [35:0] rdata
);

    logic [5:0] w;
    logic [2:0] psh;

    // word width; without parity the ninth bit of each lane is unused
    assign w = parity ? 6'(6'd9 << (wcode - 3'd3)) : 6'(6'd1 << wcode);
    assign psh = wcode - 3'd3;

    for (genvar p = 0; p < 36; p++) begin : g_bit
        localparam int LANE = p / 9;
        localparam int POS = p % 9;

        // write: which word bit lands here, and is its byte enabled
        always_comb begin
            int j;
            int bi;
            int by;
            logic sel;
            j = 0;
            bi = 0;
            by = 0;
            sel = 1'b0;
            if (parity) begin
                sel = (LANE >> psh) == int'(wsub);
                bi = (LANE & ((1 << psh) - 1)) * 9 + POS;
                by = bi / 9;
            end else begin
                j = LANE * 8 + POS;
                sel = (POS < 8) && ((j >> wcode) == int'(wsub));
                bi = j & (int'(w) - 1);
                by = bi / 8;
            end
            // narrow shapes ignore the mask: every write is whole
            phys_m[p] = sel && (w < 6'd16 || bmask[2'(by)]);
            phys_d[p] = wdata[6'(bi)];
        end

        // read: gather word bit p from its row position
        always_comb begin
            int src;
            src = int'(rsub) * int'(w) + p;
            if (!parity) begin
                src = (src / 8) * 9 + src % 8;
            end
            rdata[p] = (6'(p) < w && src < 36) ? row[6'(src)] : 1'b0;
        end
    end

endmodule

// ==== config_dual_port_ram.sv ====
/*
 * Configurable dual-port memory block of 4,608 bits with an apb
 * register file for shape, mode, clocking options and loading.
 * Assumes: both fabric ports and the apb bus run on pclk; each port
 * marks its own clock edge with a one-cycle tick pulse.
 */
// Register access over APB and the register addresses were chosen for this implementation.
// Operation
// - storage holds 4,608 bits, parity bits included
// - modes: true dual, simple dual, single port, fifo, rom, shift
// - ram or rom contents are loaded by software before running
// - shapes 4Kx1 up to 128x36 selectable per port
// - true dual-port forbids the 128-word 32/36-bit shape
// - simple dual-port mixes widths within one family only
// - true dual-port mixes 1..16 or 9/18, never across families
// - shift width times length times taps stays within the array
// - byte masking only for write widths 16, 18, 32, 36
// - masked-off bytes keep their previous contents
// - mask bit i covers nine-bit lane i of an 18 or 36-bit word
// - any mask combination is accepted
// - 16 and 32-bit shapes mask eight-bit lanes alike
// - input and output registers clock from either port's edge
// - only the output register may be bypassed
// - each port has own clock, select, clear and enable
// - input clear acts at once, output shows it next edge
// - output clear shows on the outputs immediately
// - shift mode reads old then writes, one step per edge
`timescale 1ns/1ns
`include "dpram_cfg.svh"

module config_dual_port_ram
    import dpram_pkg::*;
(
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // fabric port a
    input wire logic tick_a,
    input wire logic ce_a,
    input wire logic clr_a,
    input wire logic we_a,
    input wire logic [`ADDR_W-1:0] addr_a,
    input wire logic [`RAM_ROW_W-1:0] din_a,
    input wire logic [3:0] bmask_a,
    output logic [`RAM_ROW_W-1:0] dout_a,
    // fabric port b
    input wire logic tick_b,
    input wire logic ce_b,
    input wire logic clr_b,
    input wire logic we_b,
    input wire logic [`ADDR_W-1:0] addr_b,
    input wire logic [`RAM_ROW_W-1:0] din_b,
    input wire logic [3:0] bmask_b,
    output logic [`RAM_ROW_W-1:0] dout_b
);

    localparam logic [35:0] ONES = 36'hf_ffff_ffff;

    core_t q;
    core_t next_q;

    // per-port views of the fabric pins
    logic [1:0] tick;
    logic [1:0] ce;
    logic [1:0] clr;
    logic [1:0] we;
    logic [1:0][`ADDR_W-1:0] addr;
    logic [1:0][35:0] din;
    logic [1:0][3:0] bmask;

    // decoded configuration
    mode_t mode;
    logic run;
    logic parity;
    logic cfg_err;
    logic fifo;
    logic shift;
    logic [1:0][2:0] wc;
    logic [1:0][5:0] wbits;
    logic [1:0][2:0] sbits;
    logic [12:0] depth;
    logic [8:0] tapw;
    logic [20:0] shift_bits;
    logic [35:0] tapmask;

    // per-port datapath
    logic [1:0] in_tick;
    logic [1:0] out_tick;
    logic [1:0][`ADDR_W-1:0] waddr;
    logic [1:0][6:0] wrow;
    logic [1:0][6:0] rrow;
    logic [1:0][4:0] wsub;
    logic [1:0][4:0] rsub;
    logic [1:0][35:0] map_d;
    logic [1:0][35:0] map_m;
    logic [1:0][35:0] rdl;
    logic [1:0][35:0] cap;
    logic [1:0][35:0] row;

    // array ports
    logic ram_we0;
    logic ram_we1;
    logic [6:0] ram_wrow0;
    logic [35:0] ram_wd0;
    logic [35:0] ram_wm0;
    logic [6:0] ram_rrow0;
    logic [35:0] shift_row;
    logic [1:0] wr_ok;
    logic push;
    logic pop;
    logic step;

    // apb phases
    logic setup;
    logic access;
    logic init_wr;
    logic mapped;
    logic [31:0] rd_mux;

    assign tick = {tick_b, tick_a};
    assign ce = {ce_b, ce_a};
    assign clr = {clr_b, clr_a};
    assign we = {we_b, we_a};
    assign addr = {addr_b, addr_a};
    assign din = {din_b, din_a};
    assign bmask = {bmask_b, bmask_a};

    // configuration fields
    assign mode = mode_t'(q.cfg[`CFG_MODE +: 3]);
    assign run = q.cfg[`CFG_RUN];
    assign parity = q.cfg[`CFG_PAR];
    assign fifo = mode == MODE_FIFO;
    assign shift = mode == MODE_SHIFT;
    assign depth = 13'd128 << sbits[0];
    assign tapw = 9'(wbits[0] * q.tap_cnt);
    assign shift_bits = 21'(wbits[0]) * 21'(q.tap_len) * 21'(q.tap_cnt);
    assign tapmask = ~(ONES << tapw);

    // illegal shapes and modes block every port write, push, pop and shift step; software loading and reads still run
    always_comb begin
        cfg_err = q.cfg[`CFG_MODE +: 3] > 3'h5;
        for (int p = 0; p < 2; p++) begin
            cfg_err |= wc[p] > 3'h5;
            cfg_err |= parity && wc[p] < 3'h3;
            cfg_err |= mode == MODE_TDP && wc[p] == 3'h5;
        end
        if (shift) begin
            cfg_err |= shift_bits > 21'(`RAM_BITS);
            cfg_err |= tapw > 9'(`TAP_WMAX);
            cfg_err |= q.tap_len > 12'(`RAM_ROWS) || q.tap_len == 12'h000;
            cfg_err |= q.tap_cnt == 3'h0;
        end
    end

    // per-port clocking, address split and lane mapping
    for (genvar p = 0; p < 2; p++) begin : g_port
        // fifo runs both sides at the write width
        assign wc[p] = fifo ? q.cfg[`CFG_W +: 3] : q.cfg[`CFG_W + 3 * p +: 3];
        assign wbits[p] = parity ? 6'(6'd9 << (wc[p] - 3'd3)) : 6'(6'd1 << wc[p]);
        assign sbits[p] = 3'd5 - wc[p];
        // either edge may clock a port's registers
        assign in_tick[p] = (q.cfg[`CFG_ISEL + p] ? tick[1 - p] : tick[p]) & ce[p];
        assign out_tick[p] = (q.cfg[`CFG_OSEL + p] ? tick[1 - p] : tick[p]) & ce[p];
        assign waddr[p] = (fifo && p == 0) ? q.wptr : addr[p];
        assign wrow[p] = 7'(waddr[p] >> sbits[p]);
        assign wsub[p] = 5'(waddr[p] & ~(12'hfff << sbits[p]));
        assign rrow[p] = 7'(q.addr_q[p] >> sbits[p]);
        assign rsub[p] = 5'(q.addr_q[p] & ~(12'hfff << sbits[p]));

        lane_map u_map (
            .wcode(wc[p]),
            .parity(parity),
            .wsub(wsub[p]),
            .wdata(din[p]),
            .bmask(bmask[p]),
            .phys_d(map_d[p]),
            .phys_m(map_m[p]),
            .rsub(rsub[p]),
            .row(row[p]),
            .rdata(rdl[p])
        );

        // shift taps come straight from the row before it is rewritten
        assign cap[p] = (shift && p == 0) ? (row[0] & tapmask) : rdl[p];
    end

    // write qualification per mode
    always_comb begin
        wr_ok[0] = run && !cfg_err && in_tick[0] && we[0] && !clr[0];
        wr_ok[1] = run && !cfg_err && in_tick[1] && we[1] && !clr[1];
        push = wr_ok[0] && fifo && q.count != depth;
        // in fifo mode the b select requests a pop
        pop = wr_ok[1] && fifo && q.count != 13'h0000;
        step = wr_ok[0] && shift;
        wr_ok[0] &= mode inside {MODE_TDP, MODE_SDP, MODE_SP} || push;
        wr_ok[1] &= mode == MODE_TDP;
    end

    // shift row: older taps move up one slot, new sample enters slot 0
    assign shift_row = (36'(row[0] << wbits[0]) | (din[0] & ~(ONES << wbits[0]))) & tapmask;

    // array port a carries loading, shifting and port a writes
    always_comb begin
        ram_we0 = 1'b0;
        ram_wrow0 = wrow[0];
        ram_wd0 = map_d[0];
        ram_wm0 = map_m[0];
        ram_rrow0 = rrow[0];
        if (!run) begin
            ram_we0 = init_wr;
            ram_wrow0 = q.init_addr;
            ram_wd0 = {q.init_hi, pwdata};
            ram_wm0 = ONES;
            ram_rrow0 = q.init_addr;
        end else if (shift) begin
            ram_we0 = step;
            ram_wrow0 = q.sptr;
            ram_wd0 = shift_row;
            ram_wm0 = ONES;
            ram_rrow0 = q.sptr;
        end else begin
            ram_we0 = wr_ok[0] && mode != MODE_ROM;
        end
    end
    assign ram_we1 = wr_ok[1];

    ram_array #(
        .ROWS(`RAM_ROWS),
        .ROW_W(`RAM_ROW_W)
    ) u_ram (
        .pclk(pclk),
        .we0(ram_we0),
        .wrow0(ram_wrow0),
        .wd0(ram_wd0),
        .wm0(ram_wm0),
        .we1(ram_we1),
        .wrow1(wrow[1]),
        .wd1(map_d[1]),
        .wm1(map_m[1]),
        .rrow0(ram_rrow0),
        .rrow1(rrow[1]),
        .rd0(row[0]),
        .rd1(row[1])
    );

    // apb decode; no wait state, read data comes from a flop loaded in the setup cycle
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = access;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr && access;
    assign init_wr = access && pwrite && !q.pslverr && paddr == `REG_INIT_LO && !run;
    assign mapped = paddr inside {`REG_CFG, `REG_STAT, `REG_INIT_ADDR, `REG_INIT_LO, `REG_INIT_HI, `REG_SHIFT};

    // read mux; row contents are only meaningful while stopped
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `REG_CFG: rd_mux = 32'(q.cfg);
            `REG_STAT: begin
                rd_mux[`STAT_ERR] = cfg_err;
                rd_mux[`STAT_EMPTY] = q.count == 13'h0000;
                rd_mux[`STAT_FULL] = q.count == depth;
                rd_mux[`STAT_CNT +: 13] = q.count;
            end
            `REG_INIT_ADDR: rd_mux = 32'(q.init_addr);
            `REG_INIT_LO: rd_mux = row[0][31:0];
            `REG_INIT_HI: rd_mux = 32'(row[0][35:32]);
            `REG_SHIFT: begin
                rd_mux[`SHIFT_LEN +: 12] = q.tap_len;
                rd_mux[`SHIFT_TAPS +: 3] = q.tap_cnt;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // next state
    always_comb begin
        next_q = q;
        next_q.pslverr = setup && !mapped;
        if (setup) begin
            next_q.prdata = mapped && !pwrite ? rd_mux : 32'h0000_0000;
        end
        // register writes take effect in the access cycle
        if (access && pwrite && !q.pslverr) begin
            unique case (paddr)
                `REG_CFG: next_q.cfg = pwdata[`CFG_BITS-1:0];
                `REG_INIT_ADDR: next_q.init_addr = pwdata[6:0];
                `REG_INIT_HI: next_q.init_hi = pwdata[3:0];
                `REG_SHIFT: begin
                    next_q.tap_len = pwdata[`SHIFT_LEN +: 12];
                    next_q.tap_cnt = pwdata[`SHIFT_TAPS +: 3];
                end
                default: next_q.cfg = q.cfg;
            endcase
        end
        // loading walks the rows so software streams words
        if (init_wr) begin
            next_q.init_addr = q.init_addr + 7'h01;
        end
        // pointers restart whenever the block is stopped
        if (!run) begin
            next_q.wptr = '0;
            next_q.rptr = '0;
            next_q.count = 13'h0000;
            next_q.sptr = 7'h00;
        end else begin
            if (push) begin
                next_q.wptr = (13'(q.wptr) + 13'h0001 == depth) ? '0 : q.wptr + 12'h001;
            end
            if (pop) begin
                next_q.rptr = (13'(q.rptr) + 13'h0001 == depth) ? '0 : q.rptr + 12'h001;
            end
            next_q.count = q.count + 13'(push) - 13'(pop);
            if (step) begin
                next_q.sptr = (12'(q.sptr) + 12'h001 == q.tap_len) ? 7'h00 : q.sptr + 7'h01;
            end
        end
        for (int p = 0; p < 2; p++) begin
            // input register: clear now, output follows at next edge
            if (clr[p]) begin
                next_q.addr_q[p] = '0;
            end else if (fifo && p == 1) begin
                if (pop) begin
                    next_q.addr_q[p] = q.rptr;
                end
            end else if (in_tick[p] && run) begin
                next_q.addr_q[p] = addr[p];
            end
            // output register holds unless cleared or its edge is enabled
            if (clr[p]) begin
                next_q.out_q[p] = '0;
            end else if (out_tick[p] && run) begin
                next_q.out_q[p] = cap[p];
            end
        end
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // bypass hands the array word out unregistered
    assign dout_a = clr[0] ? '0 : (q.cfg[`CFG_BYP] ? cap[0] : q.out_q[0]);
    assign dout_b = clr[1] ? '0 : (q.cfg[`CFG_BYP + 1] ? cap[1] : q.out_q[1]);

endmodule

// ==== dpram_sva.sv ====
/*
 * Checker for the configurable memory block: bus timing, clears and
 * output holding while both fabric ports are idle.
 * Assumes: one clock pclk for bus and ports; bound by the bind below.
 */
`timescale 1ns/1ns

module dpram_sva (
    // bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // fabric ports
    input wire logic tick_a,
    input wire logic ce_a,
    input wire logic clr_a,
    input wire logic we_a,
    input wire logic [3:0] bmask_a,
    input wire logic [35:0] dout_a,
    input wire logic ce_b,
    input wire logic clr_b,
    input wire logic [35:0] dout_b
);
    logic quiet;
    logic [1:0] qcnt;

    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // no port enable, clear or bus access this cycle
    assign quiet = !ce_a && !ce_b && !clr_a && !clr_b && !psel;

    // quiet stretch length; three cycles drain the read pipeline
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qcnt <= 2'd0;
        end else begin
            qcnt <= !quiet ? 2'd0 : ((qcnt == 2'd3) ? qcnt : qcnt + 2'd1);
        end
    end

    ready_match_a: assert property (pready == (psel && penable))
        else $error("pready differs from access phase");
    bad_addr_err_a: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access without error");
    good_addr_ok_a: assert property (psel && penable && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access flagged as error");
    rdata_hold_a: assert property ($past(psel && penable) && !(psel && !penable) |-> $stable(prdata))
        else $error("read data moved after access");
    porta_clr_a: assert property (clr_a |-> dout_a == 36'h0)
        else $error("port a output not zero during clear");
    portb_clr_a: assert property (clr_b |-> dout_b == 36'h0)
        else $error("port b output not zero during clear");
    porta_hold_a: assert property (quiet && qcnt == 2'd3 |-> $stable(dout_a))
        else $error("port a output moved while idle");
    portb_hold_a: assert property (quiet && qcnt == 2'd3 |-> $stable(dout_b))
        else $error("port b output moved while idle");

    // main scenarios
    masked_write_c: cover property (tick_a && ce_a && we_a && bmask_a != 4'hf);
    clear_seen_c: cover property (clr_a ##1 !clr_a);
    bad_addr_c: cover property (psel && penable && pslverr);
endmodule

bind config_dual_port_ram dpram_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tick_a(tick_a), .ce_a(ce_a),
    .clr_a(clr_a), .we_a(we_a), .bmask_a(bmask_a), .dout_a(dout_a), .ce_b(ce_b),
    .clr_b(clr_b), .dout_b(dout_b)
);

// ==== fabric_port.sv ====
/*
 * Model of the fabric logic that drives one port of the memory block.
 * Assumes: the port clock edge is a one-cycle tick on pclk; bypassed
 * read data is settled by the falling edge after the tick edge.
 */
`timescale 1ns/1ns

module fabric_port (
    // clock
    input wire logic pclk,
    // port controls, driven by this model only
    output logic tick,
    output logic ce,
    output logic clr,
    output logic we,
    output logic [11:0] addr,
    output logic [35:0] din,
    output logic [3:0] bmask,
    // read data back
    input wire logic [35:0] dout
);
    // idle levels; the port clock stands still outside accesses
    initial begin
        tick = 1'b0;
        ce = 1'b0;
        clr = 1'b0;
        we = 1'b0;
        addr = 12'h0;
        din = 36'h0;
        bmask = 4'h0;
    end

    // one port-clock edge with its own enable and select
    task automatic access(input logic w, input logic en, input logic [11:0] a,
                          input logic [35:0] d, input logic [3:0] m);
        @(posedge pclk);
        tick <= 1'b1;
        ce <= en;
        we <= w;
        addr <= a;
        din <= d;
        bmask <= m;
        @(posedge pclk);
        tick <= 1'b0;
        ce <= 1'b0;
        we <= 1'b0;
        // released lines show the inverse
        addr <= ~a;
        din <= ~d;
        bmask <= ~m;
    endtask

    // one read tick; dout sampled mid-cycle after it
    task automatic read(input logic [11:0] a, output logic [35:0] q);
        access(1'b0, 1'b1, a, 36'h0, 4'h0);
        @(negedge pclk);
        q = dout;
    endtask

    // one-cycle clear, output sampled while it is held
    task automatic clear(output logic [35:0] q);
        @(posedge pclk);
        clr <= 1'b1;
        @(negedge pclk);
        q = dout;
        @(posedge pclk);
        clr <= 1'b0;
    endtask
endmodule

// ==== tb.sv ====
/*
 * Self-checking bench for the configurable memory block: bus master
 * tasks, two fabric port models, shape, mask and clear scenarios.
 * Assumes: design files and the checker are compiled before this.
 */
`timescale 1ns/1ns
`include "dpram_cfg.svh"

module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q32;
    logic tick_a, ce_a, clr_a, we_a, tick_b, ce_b, clr_b, we_b;
    logic [11:0] addr_a, addr_b;
    logic [35:0] din_a, din_b, dout_a, dout_b, q, row, d;
    logic [3:0] bmask_a, bmask_b;
    int mismatches = 0, checks_done = 0;
    logic [31:0] cfg_tab [9] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h328, 32'h320, 32'h211, 32'h6};
    logic err_tab [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [3:0] m_tab [4] = '{4'h5, 4'ha, 4'h0, 4'hf};

    config_dual_port_ram uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tick_a(tick_a), .ce_a(ce_a), .clr_a(clr_a), .we_a(we_a), .addr_a(addr_a),
        .din_a(din_a), .bmask_a(bmask_a), .dout_a(dout_a), .tick_b(tick_b), .ce_b(ce_b),
        .clr_b(clr_b), .we_b(we_b), .addr_b(addr_b), .din_b(din_b), .bmask_b(bmask_b),
        .dout_b(dout_b)
    );
    fabric_port pa (.pclk(pclk), .tick(tick_a), .ce(ce_a), .clr(clr_a), .we(we_a),
        .addr(addr_a), .din(din_a), .bmask(bmask_a), .dout(dout_a));
    fabric_port pb (.pclk(pclk), .tick(tick_b), .ce(ce_b), .clr(clr_b), .we(we_b),
        .addr(addr_b), .din(din_b), .bmask(bmask_b), .dout(dout_b));

    initial pclk = 1'b0;
    always #2 pclk = ~pclk; // 250 MHz

    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one bus transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            print_verdict();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic x;
        apb(1'b1, a, wd, r, x);
    endtask

    // expected row after a masked write of nine-bit lanes
    function automatic logic [35:0] merge9(input logic [35:0] old, input logic [35:0] nw, input logic [3:0] m);
        logic [35:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (m[k]) begin
                r[9*k +: 9] = nw[9*k +: 9];
            end
        end
        return r;
    endfunction

    initial begin // hang guard
        repeat (100000) @(posedge pclk);
        mismatches++;
        print_verdict();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset value and an unmapped offset
        apb(1'b0, `REG_CFG, 32'h0, q32, e);
        check({4'h0, q32}, 36'h0);
        apb(1'b0, 8'h18, 32'h0, q32, e);
        check({35'h0, e}, 36'h1);
        check({4'h0, q32}, 36'h0);
        // every mode but shift, an illegal mode code and forbidden shapes
        for (int i = 0; i < 9; i++) begin
            wr(`REG_CFG, cfg_tab[i]);
            apb(1'b0, `REG_STAT, 32'h0, q32, e);
            check({35'h0, q32[`STAT_ERR]}, {35'h0, err_tab[i]});
        end
        // software load of row 0, address steps after the low word
        wr(`REG_INIT_ADDR, 32'h0);
        wr(`REG_INIT_HI, 32'ha);
        wr(`REG_INIT_LO, 32'h12345678);
        apb(1'b0, `REG_INIT_ADDR, 32'h0, q32, e);
        check({4'h0, q32}, 36'h1);
        wr(`REG_INIT_ADDR, 32'h0);
        apb(1'b0, `REG_INIT_LO, 32'h0, q32, e);
        check({4'h0, q32}, 36'h12345678);
        apb(1'b0, `REG_INIT_HI, 32'h0, q32, e);
        check({4'h0, q32}, 36'ha);
        // single port, 128x36 with parity, bypassed output
        wr(`REG_CFG, 32'h1076a);
        row = 36'ha12345678;
        pa.read(12'h0, q);
        check(q, row);
        for (int i = 0; i < 4; i++) begin
            d = 36'h3c3c3c3c3 ^ {36{i[0]}};
            pa.access(1'b1, 1'b1, 12'h0, d, m_tab[i]);
            row = merge9(row, d, m_tab[i]);
            pa.read(12'h0, q);
            check(q, row);
        end
        // write with the enable low leaves the row alone
        pa.access(1'b1, 1'b0, 12'h0, ~row, 4'hf);
        pa.read(12'h0, q);
        check(q, row);
        // clears zero the outputs at once
        pa.clear(q);
        check(q, 36'h0);
        pb.clear(q);
        check(q, 36'h0);
        // 32-bit shape, eight-bit lanes
        wr(`REG_CFG, 32'h1056a);
        pa.access(1'b1, 1'b1, 12'h0, 36'hdeadbeef, 4'hf);
        pa.access(1'b1, 1'b1, 12'h0, 36'h0, 4'h6);
        pa.read(12'h0, q);
        check({4'h0, q[31:0]}, 36'hde0000ef);
        // 8-bit shape: the mask has no say
        wr(`REG_CFG, 32'h104da);
        pa.access(1'b1, 1'b1, 12'h0, 36'h5a, 4'h0);
        pa.read(12'h0, q);
        check({28'h0, q[7:0]}, 36'h5a);
        wr(`REG_CFG, 32'h100d9);
        pa.access(1'b1, 1'b1, 12'h5, 36'h3c, 4'h0);
        pb.read(12'h5, q);
        check(q, 36'h5a);
        pb.read(12'h5, q);
        check(q, 36'h3c);
        print_verdict();
    end
endmodule
